/* File: core/poll_chan_params.svh */
`ifndef POLL_CHAN_PARAMS_SVH
`define POLL_CHAN_PARAMS_SVH
`define DIAG_HANDSHAKE 4'h0
`define DIAG_SENT 4'h1
`define DIAG_GOOD_RX 4'h2
`define DIAG_UNDELIV 4'h3
`define DIAG_RESEND 4'h4
`define DIAG_NORM_LAST 4'h5
`define DIAG_NORM_PEAK 4'h6
`define DIAG_BAD_PKT 4'h7
`define DIAG_FIRST_EOT 4'h8
`define DIAG_DUP_PKT 4'h9
`define DIAG_PRIO_LAST 4'hA
`define DIAG_CARRIER 4'hB
`define DIAG_MODEM_LOSS 4'hC
`define DIAG_PRIO_PEAK 4'hD
`define DIAG_WORDS 14
`define BIT_CTS 0
`define BIT_RTS 1
`define BIT_DSR 2
`define BIT_DCD 3
`define BIT_DTR 4
`define TICK_MS 100
`define CLK_MHZ 200
`define TICK_CYCLES (`TICK_MS * 1000 * `CLK_MHZ)
`define BROADCAST_ADDR 8'hFF
`define FIRST_INDEX 8'h01
`endif

/* File: core/poll_chan_pkg.sv */
package poll_chan_pkg;
	typedef struct packed
	{
		logic sent;
		logic resend;
		logic good_rx;
		logic undeliverable;
		logic bad_packet;
		logic duplicate;
		logic first_poll_eot;
	} event_type;
	typedef struct packed
	{
		logic dtr;
		logic rts;
		logic dcd;
		logic dsr;
		logic cts;
	} lines_type;
	typedef enum logic [3:0]
	{
		pick_st = 4'h1,
		poll_st = 4'h2,
		wait_st = 4'h4,
		next_st = 4'h8
	} poll_state_type;
endpackage

/* File: core/poll_chan_status.sv */
`include "poll_chan_params.svh"
// Contract
// R1: Count low-to-high edges of synchronised carrier detect in word 11.
// R2: Count low-to-high edges of modem lost flag in word 12.
// R3: Count every transmitted message, retries included, in word 1.
// R4: Count error-free received messages in word 2.
// R5: Count undeliverable messages in word 3.
// R6: Count resent messages in word 4.
// R7: Count received packets identical to previous one in word 9.
// R8: Count EOT answers to first poll of a station in word 8.
// R9: Count incorrect received data packets in word 7.
// R10: Time normal list scans in 100 ms; keep last and peak.
// R11: Time priority list scans in 100 ms; keep last and peak.
// R12: Word 0 shows HANDSHAKE_LINE_STATES live on bits 4..0.
// R13: Clear request zeroes all counters together.
// R14: Software writes station total into list word 0.
// R15: Device writes current poll index into list word 1; the code keeps it in norm_idx/prio_idx and never writes list word 1.
// R16: Stations sit from list word 2 onward, polled in stored order.
// R17: Software stores octal station addresses converted correctly.
// R18: One active bit per station, station 0 at bit 0.
// R19: Newer variant clears all active bits at reset.
// R20: Legacy variant sets all active bits; clears on poll failure.
// R21: Broadcast address 377 octal is never polled as a station.
// R22: Retry poll up to retry count; then mark station inactive.
// R23: Poll group count of normal stations, then back to priority.
// R24: Counters are 16 bits and wrap to zero.
// R25: After last entry the poll index returns to one.
module poll_chan_status #(
	parameter int TICK_CYCLES = `TICK_CYCLES,
	parameter int LIST_WORDS = 64,
	parameter int STATIONS = 256,
	parameter bit LEGACY = 1'b0
)(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic clear_req,
	input wire logic dcd_pin,
	input wire logic dsr_pin,
	input wire logic cts_pin,
	input wire logic dtr_out,
	input wire logic rts_out,
	input wire logic modem_lost,
	input wire poll_chan_pkg::event_type events,
	input wire logic [3:0] retry_limit,
	input wire logic [7:0] group_count,
	input wire logic list_wr,
	input wire logic list_prio,
	input wire logic [5:0] list_addr,
	input wire logic [15:0] list_wdata,
	input wire logic [7:0] act_addr,
	output logic act_bit,
	output logic poll_req,
	output logic [7:0] poll_station,
	input wire logic poll_ok,
	input wire logic poll_fail,
	output logic [7:0] norm_index,
	output logic [7:0] prio_index
);
	typedef logic [15:0] cnt_type;
	typedef struct packed
	{
		logic [1:0] dcd_s;
		logic [1:0] dsr_s;
		logic [1:0] cts_s;
		logic dcd_q;
		logic lost_q;
		cnt_type [`DIAG_WORDS-1:0] diag;
		logic [31:0] tick;
		cnt_type norm_time;
		cnt_type prio_time;
		poll_chan_pkg::poll_state_type st;
		logic in_prio;
		logic [7:0] group_done;
		logic [3:0] tries;
		logic [7:0] norm_idx;
		logic [7:0] prio_idx;
		logic [STATIONS-1:0] active;
		logic req;
		logic [7:0] station;
		logic [15:0] rdata;
	} state_type;
	state_type cur, next_cur;
	logic [15:0] norm_list [LIST_WORDS];
	logic [15:0] prio_list [LIST_WORDS];
	logic [15:0] n_total, p_total, cur_entry;
	logic [7:0] idx;
	logic tick_hit;
	always_ff @(posedge core_clk)
	begin
		if (list_wr && list_prio)
			prio_list[list_addr] <= list_wdata; // R14
		else if (list_wr)
			norm_list[list_addr] <= list_wdata; // R16
	end
	assign n_total = norm_list[0];
	assign p_total = prio_list[0];
	assign idx = cur.in_prio ? cur.prio_idx : cur.norm_idx;
	assign cur_entry = cur.in_prio ? prio_list[6'(idx + 8'h01)]
		: norm_list[6'(idx + 8'h01)]; // R16
	assign tick_hit = (cur.tick == 32'(TICK_CYCLES - 1));
	function automatic cnt_type bump(input cnt_type v, input logic ev);
		bump = ev ? cnt_type'(v + 16'h0001) : v; // R24
	endfunction
	always_comb
	begin
		logic [15:0] total;
		logic wrap;
		total = 16'h0000;
		wrap = 1'b0;
		next_cur = cur;
		next_cur.dcd_s = {cur.dcd_s[0], dcd_pin};
		next_cur.dsr_s = {cur.dsr_s[0], dsr_pin};
		next_cur.cts_s = {cur.cts_s[0], cts_pin};
		next_cur.dcd_q = cur.dcd_s[1];
		next_cur.lost_q = modem_lost;
		next_cur.diag[`DIAG_HANDSHAKE] = {11'h000, dtr_out, cur.dcd_s[1],
			cur.dsr_s[1], rts_out, cur.cts_s[1]}; // R12
		next_cur.diag[`DIAG_CARRIER] = bump(cur.diag[`DIAG_CARRIER],
			cur.dcd_s[1] && !cur.dcd_q); // R1
		next_cur.diag[`DIAG_MODEM_LOSS] = bump(cur.diag[`DIAG_MODEM_LOSS],
			modem_lost && !cur.lost_q); // R2
		next_cur.diag[`DIAG_SENT] = bump(cur.diag[`DIAG_SENT],
			events.sent || events.resend); // R3
		next_cur.diag[`DIAG_GOOD_RX] = bump(cur.diag[`DIAG_GOOD_RX],
			events.good_rx); // R4
		next_cur.diag[`DIAG_UNDELIV] = bump(cur.diag[`DIAG_UNDELIV],
			events.undeliverable); // R5
		next_cur.diag[`DIAG_RESEND] = bump(cur.diag[`DIAG_RESEND],
			events.resend); // R6
		next_cur.diag[`DIAG_DUP_PKT] = bump(cur.diag[`DIAG_DUP_PKT],
			events.duplicate); // R7
		next_cur.diag[`DIAG_FIRST_EOT] = bump(cur.diag[`DIAG_FIRST_EOT],
			events.first_poll_eot); // R8
		next_cur.diag[`DIAG_BAD_PKT] = bump(cur.diag[`DIAG_BAD_PKT],
			events.bad_packet); // R9
		next_cur.tick = tick_hit ? 32'h0000_0000 : cur.tick + 32'h0000_0001;
		next_cur.norm_time = bump(cur.norm_time, tick_hit); // R10
		next_cur.prio_time = bump(cur.prio_time, tick_hit); // R11
		next_cur.req = 1'b0;
		total = cur.in_prio ? p_total : n_total;
		wrap = (16'(idx) >= total);
		case (cur.st)
			poll_chan_pkg::pick_st:
			begin
				if (total == 16'h0000 || total > 16'(LIST_WORDS - 2))
				begin
					next_cur.in_prio = !cur.in_prio;
					next_cur.group_done = 8'h00;
				end
				else if (cur_entry[7:0] == `BROADCAST_ADDR ||
					(!cur.in_prio && !cur.active[cur_entry[7:0]] && !LEGACY))
					next_cur.st = poll_chan_pkg::next_st; // R21
				else
				begin
					next_cur.station = cur_entry[7:0];
					next_cur.req = 1'b1;
					next_cur.tries = 4'h0;
					next_cur.st = poll_chan_pkg::wait_st;
				end
			end
			poll_chan_pkg::poll_st:
			begin
				next_cur.req = 1'b1;
				next_cur.st = poll_chan_pkg::wait_st;
			end
			poll_chan_pkg::wait_st:
			begin
				if (poll_ok)
				begin
					next_cur.active[cur.station] = 1'b1;
					if (!cur.in_prio)
						next_cur.group_done = cur.group_done + 8'h01;
					next_cur.st = poll_chan_pkg::next_st;
				end
				else if (poll_fail && cur.tries < retry_limit)
				begin
					next_cur.tries = cur.tries + 4'h1; // R22
					next_cur.st = poll_chan_pkg::poll_st;
				end
				else if (poll_fail)
				begin
					next_cur.active[cur.station] = 1'b0; // R20
					next_cur.st = poll_chan_pkg::next_st;
				end
			end
			poll_chan_pkg::next_st:
			begin
				next_cur.st = poll_chan_pkg::pick_st;
				if (cur.in_prio)
				begin
					next_cur.prio_idx = wrap ? `FIRST_INDEX
						: cur.prio_idx + 8'h01; // R15
					if (wrap)
					begin
						next_cur.diag[`DIAG_PRIO_LAST] = cur.prio_time; // R11
						if (cur.prio_time > cur.diag[`DIAG_PRIO_PEAK])
							next_cur.diag[`DIAG_PRIO_PEAK] = cur.prio_time;
						next_cur.prio_time = 16'h0000;
						next_cur.in_prio = 1'b0;
						next_cur.group_done = 8'h00;
					end
				end
				else
				begin
					next_cur.norm_idx = wrap ? `FIRST_INDEX
						: cur.norm_idx + 8'h01; // R25
					if (wrap)
					begin
						next_cur.diag[`DIAG_NORM_LAST] = cur.norm_time; // R10
						if (cur.norm_time > cur.diag[`DIAG_NORM_PEAK])
							next_cur.diag[`DIAG_NORM_PEAK] = cur.norm_time;
						next_cur.norm_time = 16'h0000;
					end
					if (wrap || next_cur.group_done >= group_count)
						next_cur.in_prio = 1'b1; // R23
				end
			end
			default:
				next_cur.st = poll_chan_pkg::pick_st;
		endcase
		if (clear_req)
		begin
			for (int i = 1; i < `DIAG_WORDS; i++)
				next_cur.diag[i] = 16'h0000; // R13
		end
		next_cur.rdata = 16'h0000;
		if (reg_rd && 32'(reg_addr) < `DIAG_WORDS)
			next_cur.rdata = cur.diag[reg_addr];
	end
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cur <= '0;
			cur.st <= poll_chan_pkg::pick_st;
			cur.in_prio <= 1'b1;
			cur.norm_idx <= `FIRST_INDEX;
			cur.prio_idx <= `FIRST_INDEX;
			cur.active <= LEGACY ? '1 : '0; // R18 R19 R20
		end
		else
			cur <= next_cur;
	end
	assign reg_rdata = cur.rdata;
	assign act_bit = cur.active[act_addr]; // R18
	assign poll_req = cur.req;
	assign poll_station = cur.station;
	assign norm_index = cur.norm_idx;
	assign prio_index = cur.prio_idx;
	chk_carrier_edge: assert property (@(posedge core_clk) disable iff (rst)
		cur.dcd_s[1] && !cur.dcd_q && !clear_req |=>
		cur.diag[`DIAG_CARRIER] == $past(cur.diag[`DIAG_CARRIER]) + 16'h0001)
		else $error("carrier count missed"); // R1
	chk_sent_count: assert property (@(posedge core_clk) disable iff (rst)
		events.resend && !clear_req |=>
		cur.diag[`DIAG_SENT] == $past(cur.diag[`DIAG_SENT]) + 16'h0001)
		else $error("resend not counted as sent"); // R3
	chk_clear_all: assert property (@(posedge core_clk) disable iff (rst)
		clear_req |=> cur.diag[`DIAG_RESEND] == 16'h0000 &&
		cur.diag[`DIAG_BAD_PKT] == 16'h0000)
		else $error("clear failed"); // R13
	chk_index_range: assert property (@(posedge core_clk) disable iff (rst)
		cur.norm_idx != 8'h00 && cur.prio_idx != 8'h00)
		else $error("poll index zero"); // R25
	chk_no_broadcast: assert property (@(posedge core_clk) disable iff (rst)
		poll_req |-> poll_station != `BROADCAST_ADDR)
		else $error("broadcast polled"); // R21
	chk_fail_inactive: assert property (@(posedge core_clk) disable iff (rst)
		cur.st == poll_chan_pkg::wait_st && poll_fail && !poll_ok &&
		cur.tries >= retry_limit |=> !cur.active[$past(cur.station)])
		else $error("station not marked inactive"); // R22
	chk_peak_order: assert property (@(posedge core_clk) disable iff (rst)
		$rose(cur.st == poll_chan_pkg::pick_st) |->
		cur.diag[`DIAG_NORM_PEAK] >= cur.diag[`DIAG_NORM_LAST])
		else $error("peak below last"); // R10
	chk_read_lat: assert property (@(posedge core_clk) disable iff (rst)
		reg_rd && reg_addr == `DIAG_HANDSHAKE |=>
		reg_rdata == $past(cur.diag[`DIAG_HANDSHAKE]))
		else $error("read data wrong"); // R12
	cov_poll: cover property (@(posedge core_clk) poll_req ##[1:20] poll_ok);
	cov_retry: cover property (@(posedge core_clk)
		cur.st == poll_chan_pkg::poll_st);
	cov_wrap: cover property (@(posedge core_clk)
		$fell(cur.norm_idx == 8'h02));
endmodule

/* File: bench/slave_station_model.sv */
module slave_station_model(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic poll_req,
	input wire logic [7:0] poll_station,
	input wire logic [7:0] dead,
	output logic poll_ok = 1'b0,
	output logic poll_fail = 1'b0
);
	timeunit 1ns;
	timeprecision 100ps;
	logic busy = 1'b0;
	logic [7:0] who = 8'h00;
	int left = 0;
	always @(posedge core_clk)
	begin
		poll_ok <= 1'b0;
		poll_fail <= 1'b0;
		if (rst)
			busy <= 1'b0;
		else if (poll_req)
		begin
			// Reply after a short or a long pause
			busy <= 1'b1;
			who <= poll_station;
			left <= $urandom_range(6, 0);
		end
		else if (busy && left > 0)
			left <= left - 1;
		else if (busy)
		begin
			// The polled station answers; a dead one fails
			busy <= 1'b0;
			poll_ok <= (who !== dead);
			poll_fail <= (who === dead);
		end
	end
endmodule

/* File: bench/polling_master_channel_status_tb.sv */
`define CHECK(w, x, g) begin total_checks++; if ((g) !== (x)) begin \
	bad_count++; $display("mismatch %s expected %h seen %h", w, x, g); end end
module polling_master_channel_status_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0, retry_limit = 4'h2;
	logic [15:0] reg_wdata = 16'h0000, list_wdata = 16'h0000, reg_rdata, e;
	logic clear_req = 1'b0, dcd_pin = 1'b0, dsr_pin = 1'b0, cts_pin = 1'b0;
	logic dtr_out = 1'b0, rts_out = 1'b0, modem_lost = 1'b0, list_wr = 1'b0;
	poll_chan_pkg::event_type events = '0;
	logic [7:0] group_count = 8'h01, act_addr = 8'h00, dead = 8'hFF;
	logic list_prio = 1'b0, act_bit, poll_req, poll_ok, poll_fail;
	logic [5:0] list_addr = 6'h00;
	logic [7:0] poll_station, norm_index, prio_index, last_st = 8'h00;
	logic rd_d = 1'b0, poll_chk = 1'b0;
	logic [4:0] w;
	logic [15:0] exp_q[$];
	int bad_count = 0, total_checks = 0, run = 0, max_run = 0, n, nres = 0;
	logic [3:0] evw [7] = '{4'h8, 4'h9, 4'h7, 4'h3, 4'h2, 4'h4, 4'h1};
	poll_chan_status #(.TICK_CYCLES(10)) poll_chan_status_inst(.core_clk,
		.rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .clear_req,
		.dcd_pin, .dsr_pin, .cts_pin, .dtr_out, .rts_out, .modem_lost, .events,
		.retry_limit, .group_count, .list_wr, .list_prio, .list_addr,
		.list_wdata, .act_addr, .act_bit, .poll_req, .poll_station, .poll_ok,
		.poll_fail, .norm_index, .prio_index);
	slave_station_model slave_station_model_inst(.core_clk, .rst, .poll_req,
		.poll_station, .dead, .poll_ok, .poll_fail);
	always #2.5 core_clk = ~core_clk;
	task automatic tick(input int k = 1);
		repeat (k) @(posedge core_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] x);
		exp_q.push_back(x);
		reg_addr <= a;
		reg_rd <= 1'b1;
		tick();
	endtask
	task automatic lw(input logic p, input logic [5:0] a, input logic [15:0] d);
		list_prio <= p;
		list_addr <= a;
		list_wdata <= d;
		list_wr <= 1'b1;
		tick();
	endtask
	task automatic rest();
		{reg_rd, reg_wr, list_wr, clear_req} <= 4'h0;
		events <= '0;
		tick();
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		if (rd_d)
		begin
			e = exp_q.pop_front();
			`CHECK("reg_rdata", e, reg_rdata)
		end
		rd_d <= reg_rd;
	end
	always @(posedge core_clk)
		if (poll_req && poll_chk)
		begin
			run = (poll_station === last_st) ? run + 1 : 1;
			max_run = (run > max_run) ? run : max_run;
			last_st = poll_station;
			`CHECK("station", 1'b1, poll_station inside {8'h08, 8'h03})
			`CHECK("prio_index", 1'b1, prio_index inside {8'h01, 8'h02})
			if (dead === 8'hFF)
				`CHECK("repeat", 1, run)
		end
	initial
	begin
		tick(20000);
		bad_count++;
		report_and_stop();
	end
	initial
	begin
		void'($urandom(84));
		// Empty both lists during reset so no poll runs on unknown words
		lw(1'b0, 6'h00, 16'h0000);
		lw(1'b1, 6'h00, 16'h0000);
		list_wr <= 1'b0;
		tick();
		rst <= 1'b0;
		tick();
		reg_addr <= 4'h1;
		reg_wdata <= 16'hFFFF;
		reg_wr <= 1'b1;
		tick();
		reg_wr <= 1'b0;
		for (int i = 1; i < 16; i++)
			rd(i[3:0], 16'h0000);
		act_addr <= 8'($urandom());
		rest();
		`CHECK("act_bit", 1'b0, act_bit)
		$display("reset test done");
		for (int b = 0; b < 7; b++)
		begin
			n = $urandom_range(3, 1);
			repeat (n)
			begin
				events <= 7'(1 << b);
				tick();
				events <= '0;
				tick();
			end
			// A resend also counts as a sent message
			if (b == 5)
				nres = n;
			rd(evw[b], 16'((b == 6) ? n + nres : n));
			rest();
		end
		repeat (2)
		begin
			{modem_lost, dcd_pin} <= 2'h3;
			tick(4);
			{modem_lost, dcd_pin} <= 2'h0;
			tick(4);
		end
		rd(4'hC, 16'h0002);
		rd(4'hB, 16'h0002);
		rest();
		$display("counter test done");
		clear_req <= 1'b1;
		events <= '1;
		tick();
		rest();
		for (int i = 1; i < 14; i++)
			rd(i[3:0], 16'h0000);
		rest();
		$display("clear test done");
		repeat (4)
		begin
			w = 5'($urandom());
			{dtr_out, dcd_pin, dsr_pin, rts_out, cts_pin} <= w;
			tick(4);
			rd(4'h0, {11'h000, w});
			rest();
		end
		$display("line test done");
		lw(1'b0, 6'h00, 16'h0000);
		lw(1'b1, 6'h02, 16'h0008);
		lw(1'b1, 6'h03, 16'h0003);
		lw(1'b1, 6'h00, 16'h0002);
		rest();
		poll_chk <= 1'b1;
		act_addr <= 8'h03;
		tick(200);
		`CHECK("act_bit", 1'b1, act_bit)
		dead <= 8'h03;
		tick(300);
		`CHECK("retry run", int'(retry_limit) + 1, max_run)
		`CHECK("act_bit", 1'b0, act_bit)
		$display("poll test done");
		report_and_stop();
	end
endmodule
